/* hw/reset_source_pkg.sv */
// Package of constants and carriers for the reset source controller.
package reset_source_pkg;

   // Power-on release to hard reset pin release, in input clock cycles.
   localparam int unsigned HARD_RELEASE_CYCLES = 521;
   // Least hold time of the power-on input, in input clock cycles (party outside).
   localparam int unsigned POR_MIN_CYCLES      = 16;
   // Least length of an internally started hard or soft reset pulse.
   localparam int unsigned INTERNAL_RST_CYCLES = 16;
   localparam int unsigned CNT_W               = 10;
   localparam logic [9:0]  HARD_RELEASE_CNT    = 10'(HARD_RELEASE_CYCLES);
   localparam logic [9:0]  INTERNAL_RST_CNT    = 10'(INTERNAL_RST_CYCLES);
   // Cycles for which the hard reset wire is ignored after we let go of it. Our own low level still
   // drains through the three sync stages and the level register, and one spare cycle covers a slow pull-up.
   localparam logic [2:0]  PIN_ECHO_CNT        = 3'h5;

   // Status bit positions.
   localparam int unsigned ST_POR      = 0;
   localparam int unsigned ST_HARD_EXT = 1;
   localparam int unsigned ST_WATCHDOG = 2;
   localparam int unsigned ST_BUS_MON  = 3;
   localparam int unsigned ST_SOFT     = 4;
   localparam int unsigned ST_W        = 5;
   localparam logic [4:0]  STATUS_RESET = 5'h01;

   // Strap values held until the first power-on capture.
   localparam logic [1:0] BOOT_MODE_RESET = 2'h0;

   typedef struct packed {
      logic [1:0] boot_mode_strap;
      logic       watchdog_enable_strap;
      logic       host_8bit_strap;
      logic       host_strobe_polarity_strap;
   } strap_t;

   // Reset outputs towards the rest of the chip, all active high.
   typedef struct packed {
      logic system_pll;
      logic dll;
      logic monitor_regs;
      logic clock_synth;
      logic extended_core;
      logic peripherals;
   } reset_out_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_PORHOLD = 2'b01,
      ST_HARD    = 2'b11,
      ST_SOFTRST = 2'b10
   } flow_t;

endpackage

/* hw/pin_sync.sv */
// Three-stage synchroniser for pin level inputs.
`timescale 1ns/100ps
module pin_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic pin,
   input  wire logic reset_value,
   output logic      level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;

   // A change counts only when stages two and three agree; stage one feeds stage two alone.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q    <= 1'b1;
         s2_q    <= 1'b1;
         s3_q    <= 1'b1;
         level_q <= 1'b1;
      end else if (clk_en) begin
         s1_q <= pin ^ !reset_value;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   // Stages hold the pin relative to its reset level, so the constant reset of ones reads as reset_value.
   assign level = level_q ^ !reset_value;
endmodule

/* hw/reset_source_controller.sv */
// Reset source controller: gathers reset sources, runs the matching flow, samples straps.
`timescale 1ns/100ps
// Notes on behaviour
// - A readable status vector shows which sources caused the most recent resets.
// - Power-on reset resets the whole chip with PLL and DLL, drives the hard reset pin, resets the core and samples straps.
// - Straps are captured only at power-on reset and never by hard or soft resets.
// - During a hard reset the hard reset pin is only pulled low, never driven high.
// - An external hard reset pin assertion or an internal hard reset runs the hard flow, driving the pin and resetting the core.
// - An enabled watchdog reaching zero signals a watchdog reset that starts an internal hard reset.
// - An enabled bus monitor reaching zero asserts a bus-monitor hard reset that starts an internal hard reset.
// - A boundary-scan extest, clamp or high-impedance instruction starts a soft reset that leaves the pin alone.
// - PLL and DLL state is reset only by power-on reset; clock synthesis state is reset by every reset type.
// - Every reset type resets the watchdog and bus time-out monitor registers.
// - Every reset type resets stop control, halt request and acknowledge, the core and peripherals.
// - After power-on reset release the hard reset pin stays low for 521 more input clocks.
// - Five strap levels are sampled at power-on release and must be stable then.
module reset_source_controller (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        clk_en,
   input  wire logic                        power_on_reset_n,
   input  wire logic                        hard_reset_n_in,
   output logic                             hard_reset_n_out,
   output logic                             hard_reset_n_oe,
   input  wire logic                        watchdog_enable,
   input  wire logic                        watchdog_zero,
   input  wire logic                        bus_monitor_enable,
   input  wire logic                        bus_monitor_zero,
   input  wire logic                        tap_reset_request,
   input  wire reset_source_pkg::strap_t    strap_pins,
   output reset_source_pkg::strap_t         strap_config,
   output reset_source_pkg::reset_out_t     reset_out,
   output logic [4:0]                       reset_status,
   output logic                             flow_busy
);

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronise the pin inputs.

   logic por_n_sync;
   logic hrst_n_sync;

   pin_sync u_sync_por (
      .clk         (clk),
      .rst         (rst),
      .clk_en      (clk_en),
      .pin         (power_on_reset_n),
      .reset_value (1'b1),
      .level       (por_n_sync)
   );

   pin_sync u_sync_hrst (
      .clk         (clk),
      .rst         (rst),
      .clk_en      (clk_en),
      .pin         (hard_reset_n_in),
      .reset_value (1'b1),
      .level       (hrst_n_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Event decode.

   reset_source_pkg::flow_t flow_q;
   reset_source_pkg::flow_t flow_d;
   logic [9:0]              cnt_q;
   logic [9:0]              cnt_d;
   logic                    por_seen_q;
   logic                    por_n_prev_q;
   logic [4:0]              status_q;
   logic [4:0]              status_d;
   reset_source_pkg::strap_t straps_q;
   logic [2:0]              echo_q;

   // The sync stage starts high after reset, so the pin sits released until seen low.
   wire por_active   = !por_n_sync;
   wire por_release  = por_n_sync && !por_n_prev_q;
   // The pin reads back our own pull, and keeps reading it through the synchroniser after we let go,
   // so an outside assertion only counts when we are not driving and that echo has drained.
   // Without the mask every flow that drives the pin would restart itself as a hard reset.
   wire echo_clear   = (echo_q == 3'h0);
   wire hard_ext     = !hrst_n_sync && !hard_reset_n_oe && echo_clear;
   wire wdog_event   = watchdog_enable && watchdog_zero;
   wire bmon_event   = bus_monitor_enable && bus_monitor_zero;
   wire hard_request = hard_ext || wdog_event || bmon_event;
   wire soft_request = tap_reset_request;
   wire cnt_done     = (cnt_q == 10'h000);

   ////////////////////////////////////////////////////////////////////////////////
   // Flow selection: power-on wins over hard, hard over soft.

   always_comb begin
      flow_d = flow_q;
      cnt_d  = cnt_q;
      if (!cnt_done) begin
         cnt_d = cnt_q - 10'h001;
      end
      if (por_active) begin
         flow_d = reset_source_pkg::ST_PORHOLD;
         cnt_d  = reset_source_pkg::HARD_RELEASE_CNT;
      end else begin
         unique case (flow_q)
            reset_source_pkg::ST_IDLE: begin
               if (hard_request) begin
                  flow_d = reset_source_pkg::ST_HARD;
                  cnt_d  = reset_source_pkg::INTERNAL_RST_CNT;
               end else if (soft_request) begin
                  flow_d = reset_source_pkg::ST_SOFTRST;
                  cnt_d  = reset_source_pkg::INTERNAL_RST_CNT;
               end
            end
            reset_source_pkg::ST_PORHOLD: begin
               if (cnt_done) begin
                  flow_d = reset_source_pkg::ST_IDLE;
               end
            end
            reset_source_pkg::ST_HARD: begin
               if (cnt_done) begin
                  flow_d = reset_source_pkg::ST_IDLE;
               end
            end
            reset_source_pkg::ST_SOFTRST: begin
               if (hard_request) begin
                  flow_d = reset_source_pkg::ST_HARD;
                  cnt_d  = reset_source_pkg::INTERNAL_RST_CNT;
               end else if (cnt_done && !soft_request) begin
                  flow_d = reset_source_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // Status: cleared by power-on, each later reset adds its source bit.
   always_comb begin
      status_d = status_q;
      if (por_active) begin
         status_d = reset_source_pkg::STATUS_RESET;
      end else if (flow_q == reset_source_pkg::ST_IDLE || flow_q == reset_source_pkg::ST_SOFTRST) begin
         if (hard_ext) begin
            status_d[reset_source_pkg::ST_HARD_EXT] = 1'b1;
         end
         if (wdog_event) begin
            status_d[reset_source_pkg::ST_WATCHDOG] = 1'b1;
         end
         if (bmon_event) begin
            status_d[reset_source_pkg::ST_BUS_MON] = 1'b1;
         end
         if (soft_request && flow_q == reset_source_pkg::ST_IDLE && !hard_request) begin
            status_d[reset_source_pkg::ST_SOFT] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State registers.

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flow_q       <= reset_source_pkg::ST_PORHOLD;
         cnt_q        <= reset_source_pkg::HARD_RELEASE_CNT;
         status_q     <= reset_source_pkg::STATUS_RESET;
         por_n_prev_q <= 1'b1;
      end else if (clk_en) begin
         flow_q       <= flow_d;
         cnt_q        <= cnt_d;
         status_q     <= status_d;
         por_n_prev_q <= por_n_sync;
      end
   end

   // Straps are caught on the clock at power-on release only; hard and soft flows never touch them.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         straps_q   <= '0;
         por_seen_q <= 1'b0;
      end else if (clk_en && por_release) begin
         straps_q   <= strap_pins;
         por_seen_q <= 1'b1;
      end
   end

   // Echo mask: reloads while we drive the pin and runs down once we let go.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         echo_q <= reset_source_pkg::PIN_ECHO_CNT;
      end else if (clk_en) begin
         if (hard_reset_n_oe) begin
            echo_q <= reset_source_pkg::PIN_ECHO_CNT;
         end else if (!echo_clear) begin
            echo_q <= echo_q - 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   wire in_por  = (flow_q == reset_source_pkg::ST_PORHOLD);
   wire in_hard = (flow_q == reset_source_pkg::ST_HARD);
   wire in_any  = (flow_q != reset_source_pkg::ST_IDLE);

   // Open drain: value is always low, only the enable moves.
   assign hard_reset_n_out = 1'b0;
   assign hard_reset_n_oe  = in_por || in_hard;

   // PLL and DLL only follow power-on; clock synthesis state and the rest follow every flow.
   assign reset_out.system_pll    = in_por;
   assign reset_out.dll           = in_por;
   assign reset_out.monitor_regs  = in_any;
   assign reset_out.clock_synth   = in_any;
   assign reset_out.extended_core = in_any;
   assign reset_out.peripherals   = in_any;

   assign strap_config = straps_q;
   assign reset_status = status_q;
   assign flow_busy    = in_any;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence s_por_release;
      clk_en && in_por && !por_active && cnt_done;
   endsequence

   property p_por_pin_hold;
      @(posedge clk) disable iff (rst)
      (clk_en && in_por && !por_active && cnt_q == reset_source_pkg::HARD_RELEASE_CNT) |-> hard_reset_n_oe;
   endproperty
   a_por_pin_hold: assert property (p_por_pin_hold) else $error("pin not held after power-on release");

   property p_por_end;
      @(posedge clk) disable iff (rst)
      s_por_release |=> (flow_q == reset_source_pkg::ST_IDLE) && !hard_reset_n_oe;
   endproperty
   a_por_end: assert property (p_por_end) else $error("power-on flow did not end on count");

   property p_open_drain;
      @(posedge clk) disable iff (rst) hard_reset_n_out == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("hard reset pin driven high");

   property p_wdog_hard;
      @(posedge clk) disable iff (rst)
      (clk_en && flow_q == reset_source_pkg::ST_IDLE && !por_active && wdog_event) |=> in_hard;
   endproperty
   a_wdog_hard: assert property (p_wdog_hard) else $error("watchdog did not start hard reset");

   property p_bmon_hard;
      @(posedge clk) disable iff (rst)
      (clk_en && flow_q == reset_source_pkg::ST_IDLE && !por_active && bmon_event) |=> in_hard && hard_reset_n_oe;
   endproperty
   a_bmon_hard: assert property (p_bmon_hard) else $error("bus monitor did not start hard reset");

   property p_soft_no_pin;
      @(posedge clk) disable iff (rst)
      (flow_q == reset_source_pkg::ST_SOFTRST) |-> !hard_reset_n_oe && reset_out.extended_core;
   endproperty
   a_soft_no_pin: assert property (p_soft_no_pin) else $error("soft reset drove the pin");

   property p_pll_por_only;
      @(posedge clk) disable iff (rst)
      reset_out.system_pll |-> in_por;
   endproperty
   a_pll_por_only: assert property (p_pll_por_only) else $error("pll reset outside power-on");

   property p_monitor_all;
      @(posedge clk) disable iff (rst)
      in_any |-> reset_out.monitor_regs && reset_out.clock_synth && reset_out.peripherals;
   endproperty
   a_monitor_all: assert property (p_monitor_all) else $error("flow missed monitor or peripheral reset");

   property p_straps_stable;
      @(posedge clk) disable iff (rst)
      (clk_en && !por_release) |=> $stable(straps_q);
   endproperty
   a_straps_stable: assert property (p_straps_stable) else $error("straps changed outside power-on release");

   property p_status_sticky;
      @(posedge clk) disable iff (rst)
      (clk_en && !por_active && status_q[reset_source_pkg::ST_WATCHDOG]) |=> status_q[reset_source_pkg::ST_WATCHDOG];
   endproperty
   a_status_sticky: assert property (p_status_sticky) else $error("status bit lost without power-on");

   // Entry into each flow, and the pin echo that must not start one.
   sequence s_soft_take;
      clk_en && flow_q == reset_source_pkg::ST_IDLE && !por_active && soft_request && !hard_request;
   endsequence

   property p_soft_start;
      @(posedge clk) disable iff (rst)
      s_soft_take |=> (flow_q == reset_source_pkg::ST_SOFTRST) && status_q[reset_source_pkg::ST_SOFT];
   endproperty
   a_soft_start: assert property (p_soft_start) else $error("soft request did not start soft flow");

   property p_hard_ext_start;
      @(posedge clk) disable iff (rst)
      (clk_en && flow_q == reset_source_pkg::ST_IDLE && !por_active && hard_ext) |=> in_hard && hard_reset_n_oe;
   endproperty
   a_hard_ext_start: assert property (p_hard_ext_start) else $error("outside pin did not start hard reset");

   property p_echo_ignored;
      @(posedge clk) disable iff (rst)
      (clk_en && flow_q == reset_source_pkg::ST_IDLE && !por_active && !echo_clear && !wdog_event && !bmon_event
         && !soft_request) |=> (flow_q == reset_source_pkg::ST_IDLE);
   endproperty
   a_echo_ignored: assert property (p_echo_ignored) else $error("own pin echo started a hard reset");

   property p_por_clears;
      @(posedge clk) disable iff (rst)
      (clk_en && por_active) |=> in_por && (status_q == reset_source_pkg::STATUS_RESET);
   endproperty
   a_por_clears: assert property (p_por_clears) else $error("power-on did not clear status");

endmodule

/* verif/board_reset_model.sv */
// Board side of the reset controller: power-on source, hard reset wire with pull-up, strap resistors.
`timescale 1ns/100ps
module board_reset_model (
   input  wire logic                     clk,
   input  wire logic                     por_request,
   input  wire logic                     hard_request,
   input  wire reset_source_pkg::strap_t strap_value,
   input  wire logic                     hard_reset_n_out,
   input  wire logic                     hard_reset_n_oe,
   output logic                         power_on_reset_n,
   output logic                         hard_reset_n_in,
   output reset_source_pkg::strap_t     strap_pins
);
   logic [4:0] hold_q = 5'h10;
   logic [3:0] after_q = 4'hF;

   ////////////////////////////////////////////////////////////////////////////
   // A request restarts the power-on pulse, which never ends before the least hold time.
   always @(posedge clk) begin
      if (por_request) begin
         hold_q <= 5'h00;
         after_q <= 4'h0;
         power_on_reset_n <= 1'b0;
      end else if (hold_q < 5'(reset_source_pkg::POR_MIN_CYCLES)) begin
         hold_q <= hold_q + 5'h01;
      end else begin
         power_on_reset_n <= 1'b1;
         if (after_q != 4'hF) begin
            after_q <= after_q + 4'h1;
         end
      end
   end

   // Straps hold steady around the release, then flip so that any late resampling shows up.
   assign strap_pins = (after_q < 4'h8) ? strap_value : ~strap_value;
   // The wire has a pull-up; either party may pull it low.
   assign hard_reset_n_in = ~(hard_request | (hard_reset_n_oe & ~hard_reset_n_out));
endmodule

/* verif/test_reset_source_controller.sv */
// Self-checking testbench for the reset source controller.
`timescale 1ns/100ps
module test_reset_source_controller;
   logic                         clk = 1'b0;
   logic                         rst = 1'b1;
   logic                         watchdog_enable = 1'b0, watchdog_zero = 1'b0;
   logic                         bus_monitor_enable = 1'b0, bus_monitor_zero = 1'b0;
   logic                         tap_reset_request = 1'b0, por_request = 1'b0, hard_request = 1'b0;
   reset_source_pkg::strap_t     strap_value = 5'h16;
   reset_source_pkg::strap_t     strap_pins, strap_config;
   reset_source_pkg::reset_out_t reset_out;
   logic                         power_on_reset_n, hard_reset_n_in, hard_reset_n_out, hard_reset_n_oe, flow_busy;
   logic [4:0]                   reset_status, exp_status;
   int                           n_errors = 0;
   int                           comparisons = 0;

   initial begin
      forever #2.5 clk = ~clk;
   end

   reset_source_controller u_reset_source_controller (
      .clk(clk), .rst(rst), .clk_en(1'b1), .power_on_reset_n(power_on_reset_n),
      .hard_reset_n_in(hard_reset_n_in), .hard_reset_n_out(hard_reset_n_out), .hard_reset_n_oe(hard_reset_n_oe),
      .watchdog_enable(watchdog_enable), .watchdog_zero(watchdog_zero),
      .bus_monitor_enable(bus_monitor_enable), .bus_monitor_zero(bus_monitor_zero),
      .tap_reset_request(tap_reset_request), .strap_pins(strap_pins), .strap_config(strap_config),
      .reset_out(reset_out), .reset_status(reset_status), .flow_busy(flow_busy));

   board_reset_model u_board_reset_model (
      .clk(clk), .por_request(por_request), .hard_request(hard_request), .strap_value(strap_value),
      .hard_reset_n_out(hard_reset_n_out), .hard_reset_n_oe(hard_reset_n_oe),
      .power_on_reset_n(power_on_reset_n), .hard_reset_n_in(hard_reset_n_in), .strap_pins(strap_pins));

   ////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and hang handling.
   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      comparisons++;
      if (seen !== expected) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   function automatic logic pick(input int sel);
      return (sel == 0) ? power_on_reset_n : ((sel == 1) ? flow_busy : hard_reset_n_oe);
   endfunction

   // Waits for a level with a cycle limit; the leading delay lets the launching edge settle.
   task automatic wait_level(input int sel, input logic lvl, input int lim, output int n);
      n = 0;
      #1;
      while (pick(sel) !== lvl) begin
         @(posedge clk);
         #1;
         n++;
         if (n > lim) begin
            n_errors++;
            $display("wait limit reached at %0t", $time);
            final_report();
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Follows one hard or soft flow cycle by cycle and checks its outputs and length.
   task automatic run_flow(input int bit_idx, input logic oe_exp);
      int n;
      wait_level(1, 1'b1, 8, n);
      exp_status[bit_idx] = 1'b1;
      check(reset_status, exp_status);
      n = 0;
      while (flow_busy === 1'b1 && n < 40) begin
         check(reset_out, 6'h0F);
         check(hard_reset_n_oe, oe_exp);
         if (hard_reset_n_oe === 1'b1) check(hard_reset_n_out, 1'b0);
         @(posedge clk);
         #1;
         n++;
      end
      check(n >= reset_source_pkg::INTERNAL_RST_CYCLES, 1'b1);
      check(n <= reset_source_pkg::INTERNAL_RST_CYCLES + 2, 1'b1);
      // A flow that never ended has been counted above; stop here rather than run on.
      if (n >= 40) final_report();
      check(strap_config, strap_value);
   endtask

   task automatic test_power_on(input reset_source_pkg::strap_t s);
      int n;
      @(posedge clk);
      strap_value <= s;
      por_request <= 1'b1;
      @(posedge clk);
      por_request <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check(reset_out, 6'h3F);
      check(hard_reset_n_oe, 1'b1);
      wait_level(0, 1'b1, 40, n);
      wait_level(2, 1'b0, 600, n);
      // The pin release also pays for the input synchroniser, hence the small allowance.
      check(n >= reset_source_pkg::HARD_RELEASE_CYCLES && n <= reset_source_pkg::HARD_RELEASE_CYCLES + 8, 1'b1);
      exp_status = 5'h01;
      check(reset_status, exp_status);
      check(strap_config, s);
      wait_level(1, 1'b0, 20, n);
      $display("test power_on done");
   endtask

   task automatic test_watchdog();
      @(posedge clk);
      watchdog_zero <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check(flow_busy, 1'b0);
      @(posedge clk);
      watchdog_enable <= 1'b1;
      @(posedge clk);
      watchdog_enable <= 1'b0;
      watchdog_zero <= 1'b0;
      run_flow(reset_source_pkg::ST_WATCHDOG, 1'b1);
      $display("test watchdog done");
   endtask

   task automatic test_bus_monitor();
      @(posedge clk);
      bus_monitor_enable <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check(flow_busy, 1'b0);
      @(posedge clk);
      bus_monitor_zero <= 1'b1;
      @(posedge clk);
      bus_monitor_enable <= 1'b0;
      bus_monitor_zero <= 1'b0;
      run_flow(reset_source_pkg::ST_BUS_MON, 1'b1);
      $display("test bus_monitor done");
   endtask

   task automatic test_external_hard();
      @(posedge clk);
      hard_request <= 1'b1;
      fork
         begin
            repeat (4) @(posedge clk);
            hard_request <= 1'b0;
         end
      join_none
      run_flow(reset_source_pkg::ST_HARD_EXT, 1'b1);
      $display("test external_hard done");
   endtask

   task automatic test_soft();
      @(posedge clk);
      tap_reset_request <= 1'b1;
      fork
         begin
            repeat (3) @(posedge clk);
            tap_reset_request <= 1'b0;
         end
      join_none
      run_flow(reset_source_pkg::ST_SOFT, 1'b0);
      $display("test soft done");
   endtask

   // A watchdog event during a held soft reset escalates to the hard flow.
   task automatic test_soft_to_hard();
      @(posedge clk);
      tap_reset_request <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(hard_reset_n_oe, 1'b0);
      @(posedge clk);
      watchdog_enable <= 1'b1;
      watchdog_zero   <= 1'b1;
      @(posedge clk);
      tap_reset_request <= 1'b0;
      watchdog_enable   <= 1'b0;
      watchdog_zero     <= 1'b0;
      run_flow(reset_source_pkg::ST_WATCHDOG, 1'b1);
      $display("test soft_to_hard done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; the second power-on uses other straps and must clear the history.
   initial begin
      int n;
      exp_status = 5'h01;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_level(1, 1'b0, 700, n);
      check(reset_status, 5'h01);
      test_power_on(5'h16);
      test_watchdog();
      test_bus_monitor();
      test_external_hard();
      test_soft();
      test_soft_to_hard();
      check(reset_status, 5'h1F);
      test_power_on(5'h09);
      final_report();
   end
endmodule
